// file: cfgw_defs.svh
// Offsets, field positions and erased values of the configuration words
`ifndef CFGW_DEFS_SVH
`define CFGW_DEFS_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CFGW_OFS_WDT      8'h00
`define CFGW_OFS_POR      8'h04
`define CFGW_OFS_ICD      8'h08
`define CFGW_OFS_IVTL     8'h0C
`define CFGW_OFS_IVTH     8'h10
`define CFGW_OFS_CNTL     8'h14
`define CFGW_OFS_CNTH     8'h18
`define CFGW_OFS_DMT      8'h1C
`define CFGW_OFS_CTRL     8'h20
`define CFGW_OFS_STAT     8'h24
// ----------------------------------------------------------------------
// Implemented bit masks and values
// ----------------------------------------------------------------------
`define CFGW_ERASED       24'hFF_FFFF
`define CFGW_MSK_WDT      24'h00_FFFF
`define CFGW_MSK_POR      24'h00_0040
`define CFGW_MSK_ICD      24'h00_0023
`define CFGW_MSK_HALF     24'h00_FFFF
`define CFGW_MSK_DMT      24'h00_0001
`define CFGW_POR_RSV_VAL  24'h00_0430
`define CFGW_POR_RSV_MSK  24'h00_0430
`define CFGW_ICD_RSV_MSK  24'h00_0080
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CFGW_B_HWEN       15
`define CFGW_B_WINDOW_DISABLE     7
`define CFGW_B_SELF_TEST_DISABLE    6
`define CFGW_B_DEBUG_PORT_ENABLE     5
`define CFGW_B_DEADMAN_DISABLE     0
`endif

// file: cfgw_pkg.sv
// Types of the configuration word bank
package cfgw_pkg;
  typedef enum logic [1:0] {
    CFGW_CLK_RSV  = 2'h0,
    CFGW_CLK_PER  = 2'h1,
    CFGW_CLK_FAST = 2'h2,
    CFGW_CLK_LOW_POWER_RC_CLOCK = 2'h3
  } cfgw_clk_t;
  typedef enum logic [2:0] {
    CFGW_LOAD = 3'b001,
    CFGW_RUN  = 3'b010,
    CFGW_RESP = 3'b100
  } cfgw_state_t;
  typedef struct packed {
    logic        hw_enable;
    logic [31:0] divide;
    logic [1:0]  window_size_select;
    logic        window_mode;
    logic [2:0]  clk_onehot;
  } cfgw_wdt_t;
  typedef struct packed {
    logic [31:0] deadman_window_interval;
    logic [31:0] deadman_count_timeout;
    logic        deadman_enabled;
  } cfgw_dmt_t;
endpackage

// file: cfgw_bank.sv
// Configuration word bank with Avalon-MM access and unit outputs
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
`include "cfgw_defs.svh"
module cfgw_bank (
  // Clock and reset
  input  wire logic               CLOCK,
  input  wire logic               SYS_RST,
  input  wire logic               POR_FLAG,
  // Avalon-MM slave
  input  wire logic [7:0]         AVS_ADDRESS,
  input  wire logic               AVS_READ,
  input  wire logic               AVS_WRITE,
  input  wire logic [31:0]        AVS_WRITEDATA,
  input  wire logic [3:0]         AVS_BYTEENABLE,
  output logic      [31:0]        AVS_READDATA,
  output logic                    AVS_WAITREQUEST,
  output logic      [1:0]         AVS_RESPONSE,
  // Device state inputs (asynchronous)
  input  wire logic               SLEEPING,
  input  wire logic               SYSCLK_INTERNAL_OSCILLATOR,
  input  wire logic               WDT_SW_ON,
  input  wire logic               DMT_SW_ON,
  // Unit outputs
  output cfgw_pkg::cfgw_wdt_t     WDT_CFG,
  output cfgw_pkg::cfgw_dmt_t     DMT_CFG,
  output logic                    SELF_TEST_RUN,
  output logic                    DEBUG_PORT_ENABLE,
  output logic      [2:0]         DEBUG_PAIR_ONEHOT
);
  import cfgw_pkg::*;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [31:0] pow2(input logic [4:0] code);
    pow2 = 32'h0000_0001 << code;
  endfunction

  function automatic logic [23:0] rd_word(input logic [23:0] v,
                                          input logic [23:0] m);
    rd_word = v | ~m;
  endfunction

  // --------------------------------------------------------------------
  // Nonvolatile array and latched copies
  // --------------------------------------------------------------------
  // Parts leave the factory erased
  logic [23:0] nv_r [8] = '{default: `CFGW_ERASED};
  logic [23:0] lat_r [8];
  logic [23:0] msk [8];
  assign msk[0] = `CFGW_MSK_WDT;
  assign msk[1] = `CFGW_MSK_POR;
  assign msk[2] = `CFGW_MSK_ICD;
  assign msk[3] = `CFGW_MSK_HALF;
  assign msk[4] = `CFGW_MSK_HALF;
  assign msk[5] = `CFGW_MSK_HALF;
  assign msk[6] = `CFGW_MSK_HALF;
  assign msk[7] = `CFGW_MSK_DMT;

  cfgw_state_t state_r;
  logic [31:0] rdata_r;
  logic [1:0]  resp_r;
  logic        wait_r;

  // Synchronisers
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic       por_s1_r;
  logic       por_s2_r;
  logic       por_lat_r;
  always_ff @(posedge CLOCK) begin
    s1_r     <= {DMT_SW_ON, WDT_SW_ON, SYSCLK_INTERNAL_OSCILLATOR, SLEEPING};
    s2_r     <= s1_r;
    por_s1_r <= POR_FLAG;
    por_s2_r <= por_s1_r;
  end

  // Decode
  logic        hit_word;
  logic [2:0]  widx;
  logic        wr_req;
  logic        rd_req;
  assign widx     = AVS_ADDRESS[4:2];
  assign hit_word = (AVS_ADDRESS[1:0] == 2'h0) &&
                    (AVS_ADDRESS < `CFGW_OFS_CTRL);
  assign wr_req   = AVS_WRITE && (state_r == CFGW_RUN);
  assign rd_req   = AVS_READ && (state_r == CFGW_RUN);

  logic [23:0] be_mask;
  assign be_mask = {{8{AVS_BYTEENABLE[2]}}, {8{AVS_BYTEENABLE[1]}},
                    {8{AVS_BYTEENABLE[0]}}};

  // --------------------------------------------------------------------
  // Programming: only clears bits; erase sets all to one
  // --------------------------------------------------------------------
  logic [23:0] rsv_keep [8];
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_nv
      always_ff @(posedge CLOCK) begin
        if (wr_req && (AVS_ADDRESS == `CFGW_OFS_CTRL) &&
            AVS_BYTEENABLE[0] && AVS_WRITEDATA[0]) begin
          nv_r[gi] <= `CFGW_ERASED;
        end else if (wr_req && hit_word && (widx == 3'(gi))) begin
          nv_r[gi] <= nv_r[gi] &
                      ~(~AVS_WRITEDATA[23:0] & be_mask & msk[gi]);
        end
      end
      assign rsv_keep[gi] = nv_r[gi];
      // Fields latch in the cycle after reset release and then hold
      always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
          lat_r[gi] <= `CFGW_ERASED;
        end else if (state_r == CFGW_LOAD) begin
          lat_r[gi] <= nv_r[gi] & msk[gi];
        end
      end
    end
  endgenerate

  // Power-on flag caught after reset release
  always_ff @(posedge CLOCK) begin
    if (state_r == CFGW_LOAD) begin
      por_lat_r <= por_s2_r;
    end
  end

  // --------------------------------------------------------------------
  // Bus state machine
  // --------------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state_r <= CFGW_LOAD;
    end else begin
      unique case (state_r)
        CFGW_LOAD: state_r <= CFGW_RUN;
        CFGW_RUN:  if (AVS_READ || AVS_WRITE) state_r <= CFGW_RESP;
        CFGW_RESP: state_r <= CFGW_RUN;
        default:   state_r <= CFGW_LOAD;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !((state_r == CFGW_RUN) && (AVS_READ || AVS_WRITE));
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rdata_r <= 32'h0000_0000;
      resp_r  <= 2'h0;
    end else if (rd_req) begin
      resp_r <= 2'h0;
      if (hit_word) begin
        rdata_r <= {8'h00, rd_word(nv_r[widx], msk[widx])};
      end else if (AVS_ADDRESS == `CFGW_OFS_CTRL) begin
        rdata_r <= 32'h0000_0000;
      end else if (AVS_ADDRESS == `CFGW_OFS_STAT) begin
        rdata_r <= {29'h0000_0000, por_lat_r,
                    (rsv_keep[2] & `CFGW_ICD_RSV_MSK) != 24'h00_0000,
                    (rsv_keep[1] & `CFGW_POR_RSV_MSK) ==
                     `CFGW_POR_RSV_VAL};
      end else begin
        rdata_r <= 32'h0000_0000;
        resp_r  <= 2'h2;
      end
    end else if (wr_req) begin
      resp_r <= (hit_word || (AVS_ADDRESS == `CFGW_OFS_CTRL)) ?
                2'h0 : 2'h2;
    end
  end

  // --------------------------------------------------------------------
  // Unit outputs
  // --------------------------------------------------------------------
  logic [23:0] w;
  logic        win_mode;
  assign w        = lat_r[0];
  assign win_mode = ~w[`CFGW_B_WINDOW_DISABLE];

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      WDT_CFG <= '0;
    end else begin
      WDT_CFG.hw_enable <= w[`CFGW_B_HWEN] | s2_r[2];
      WDT_CFG.divide <= s2_r[0] ? pow2(w[14:10]) : pow2(w[4:0]);
      WDT_CFG.window_size_select <= w[9:8];
      WDT_CFG.window_mode <= win_mode;
      // One-hot: {peripheral, fast RC, low-power RC}
      unique case (cfgw_clk_t'(w[6:5]))
        CFGW_CLK_FAST: WDT_CFG.clk_onehot <=
          (win_mode && !s2_r[1] && !s2_r[0]) ? 3'b010 : 3'b001;
        CFGW_CLK_PER:  WDT_CFG.clk_onehot <=
          (!s2_r[1] && !s2_r[0]) ? 3'b100 : 3'b001;
        default:       WDT_CFG.clk_onehot <= 3'b001;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      DMT_CFG <= '0;
    end else begin
      DMT_CFG.deadman_window_interval <=
        {lat_r[4][15:0], lat_r[3][15:0]};
      DMT_CFG.deadman_count_timeout <=
        {lat_r[6][15:0], lat_r[5][15:0]};
      DMT_CFG.deadman_enabled <=
        ~lat_r[7][`CFGW_B_DEADMAN_DISABLE] | s2_r[3];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      SELF_TEST_RUN     <= 1'b0;
      DEBUG_PORT_ENABLE <= 1'b0;
      DEBUG_PAIR_ONEHOT <= 3'b000;
    end else begin
      SELF_TEST_RUN <= (state_r == CFGW_LOAD) && por_s2_r &&
                       !nv_r[1][`CFGW_B_SELF_TEST_DISABLE];
      DEBUG_PORT_ENABLE <= lat_r[2][`CFGW_B_DEBUG_PORT_ENABLE];
      unique case (lat_r[2][1:0])
        2'h3:    DEBUG_PAIR_ONEHOT <= 3'b001;
        2'h2:    DEBUG_PAIR_ONEHOT <= 3'b010;
        2'h1:    DEBUG_PAIR_ONEHOT <= 3'b100;
        default: DEBUG_PAIR_ONEHOT <= 3'b000;
      endcase
    end
  end

  assign AVS_READDATA    = rdata_r;
  assign AVS_WAITREQUEST = wait_r;
  assign AVS_RESPONSE    = resp_r;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  sequence req_s;
    (state_r == CFGW_RUN) && (AVS_READ || AVS_WRITE);
  endsequence
  wait_answer_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    req_s |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("waitrequest not one cycle low");
  unimpl_ones_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (rd_req && hit_word && widx == 3'h7) |=>
      AVS_READDATA[23:1] == 23'h7F_FFFF)
    else $error("unimplemented bits not one");
  prog_once_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (!wr_req) |=> nv_r[0] == $past(nv_r[0]))
    else $error("word changed without write");
  latch_hold_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (state_r != CFGW_LOAD) |=> lat_r[3] == $past(lat_r[3]))
    else $error("latched word changed");
  hw_enable_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    w[`CFGW_B_HWEN] |=> WDT_CFG.hw_enable)
    else $error("watchdog not forced on");
  low_power_rc_clock_clock_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (w[6:5] == 2'h3) |=> WDT_CFG.clk_onehot == 3'b001)
    else $error("low-power clock not chosen");
  fast_rc_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (w[6:5] == 2'h2 && !win_mode) |=> WDT_CFG.clk_onehot == 3'b001)
    else $error("fast clock without window");
  per_clock_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (w[6:5] == 2'h1 && s2_r[0]) |=> WDT_CFG.clk_onehot == 3'b001)
    else $error("peripheral clock in sleep");
  dmt_lock_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !lat_r[7][0] |=> DMT_CFG.deadman_enabled)
    else $error("deadman not locked on");
  window_join_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    1'b1 |=> DMT_CFG.deadman_window_interval[31:16] ==
             $past(lat_r[4][15:0]))
    else $error("window high half wrong");
  jtag_en_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    1'b1 |=> DEBUG_PORT_ENABLE == $past(lat_r[2][5]))
    else $error("debug port enable wrong");

  // --------------------------------------------------------------------
  // Watchdog field checks
  // --------------------------------------------------------------------
  sleep_div_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s2_r[0] |=> WDT_CFG.divide ==
      (32'h0000_0001 << $past(w[14:10])))
    else $error("sleep divide wrong");
  sleep_max_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (s2_r[0] && w[14:10] == 5'h1F) |=>
      WDT_CFG.divide == 32'h8000_0000)
    else $error("sleep divide max wrong");
  run_div_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !s2_r[0] |=> WDT_CFG.divide ==
      (32'h0000_0001 << $past(w[4:0])))
    else $error("run divide wrong");
  win_code_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    1'b1 |=> WDT_CFG.window_size_select == $past(w[9:8]))
    else $error("window code wrong");
  win_mode_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    1'b1 |=> WDT_CFG.window_mode == !$past(w[7]))
    else $error("window mode wrong");
  clk_onehot_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    1'b1 |=> $onehot(WDT_CFG.clk_onehot))
    else $error("clock choice not one-hot");
  fast_pick_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (w[6:5] == 2'h2 && win_mode && !s2_r[1] && !s2_r[0]) |=>
      WDT_CFG.clk_onehot == 3'b010)
    else $error("fast clock not chosen");
  per_pick_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (w[6:5] == 2'h1 && !s2_r[1] && !s2_r[0]) |=>
      WDT_CFG.clk_onehot == 3'b100)
    else $error("peripheral clock not chosen");

  // --------------------------------------------------------------------
  // Self-test, debug and deadman checks
  // --------------------------------------------------------------------
  bist_por_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !por_s2_r |=> !SELF_TEST_RUN)
    else $error("self-test without power-on");
  bist_pulse_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    SELF_TEST_RUN |=> !SELF_TEST_RUN)
    else $error("self-test pulse too long");
  pair_one_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (lat_r[2][1:0] == 2'h3) |=> DEBUG_PAIR_ONEHOT == 3'b001)
    else $error("debug pair one wrong");
  pair_three_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (lat_r[2][1:0] == 2'h1) |=> DEBUG_PAIR_ONEHOT == 3'b100)
    else $error("debug pair three wrong");
  count_join_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    1'b1 |=> DMT_CFG.deadman_count_timeout ==
      {$past(lat_r[6][15:0]), $past(lat_r[5][15:0])})
    else $error("count timeout join wrong");
  dmt_soft_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (lat_r[7][0] && !s2_r[3]) |=> !DMT_CFG.deadman_enabled)
    else $error("deadman on without software");

  // --------------------------------------------------------------------
  // Word storage checks
  // --------------------------------------------------------------------
  por_ones_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (rd_req && hit_word && widx == 3'h1) |=>
      AVS_READDATA[23:7] == 17'h1_FFFF &&
      AVS_READDATA[5:0] == 6'h3F)
    else $error("power-on word spare bits not one");
  stat_rsv_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (rd_req && AVS_ADDRESS == `CFGW_OFS_STAT) |=>
      AVS_READDATA[1:0] == 2'h3)
    else $error("reserved bits disturbed");
  erase_all_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (wr_req && AVS_ADDRESS == `CFGW_OFS_CTRL && AVS_BYTEENABLE[0] &&
     AVS_WRITEDATA[0]) |=> nv_r[3] == `CFGW_ERASED)
    else $error("erase did not set word");
  clear_only_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (wr_req && hit_word && widx == 3'h3) |=>
      (nv_r[3] & ~$past(nv_r[3])) == 24'h00_0000)
    else $error("word write set a bit");
  wdt_hold_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (state_r != CFGW_LOAD) |=> lat_r[0] == $past(lat_r[0]))
    else $error("latched watchdog word changed");
endmodule // cfgw_bank

// file: cfgw_bank_tb.sv
// Self-checking testbench of the configuration word bank
`timescale 1ns/10ps
`include "cfgw_defs.svh"
module cfgw_bank_tb;
  import cfgw_pkg::*;
  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  logic        CLOCK;
  logic        SYS_RST;
  logic        POR_FLAG;
  logic [7:0]  AVS_ADDRESS;
  logic        AVS_READ;
  logic        AVS_WRITE;
  logic [31:0] AVS_WRITEDATA;
  logic [3:0]  AVS_BYTEENABLE;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  logic [1:0]  AVS_RESPONSE;
  logic        SLEEPING;
  logic        SYSCLK_INTERNAL_OSCILLATOR;
  logic        WDT_SW_ON;
  logic        DMT_SW_ON;
  cfgw_wdt_t   WDT_CFG;
  cfgw_dmt_t   DMT_CFG;
  logic        SELF_TEST_RUN;
  logic        DEBUG_PORT_ENABLE;
  logic [2:0]  DEBUG_PAIR_ONEHOT;
  int          n_fail;
  int          tests_run;
  int          cyc;
  int          pulses;
  logic [31:0] rdat;
  logic [1:0]  rrsp;

  cfgw_bank uut (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .POR_FLAG(POR_FLAG),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .AVS_RESPONSE(AVS_RESPONSE), .SLEEPING(SLEEPING),
    .SYSCLK_INTERNAL_OSCILLATOR(SYSCLK_INTERNAL_OSCILLATOR), .WDT_SW_ON(WDT_SW_ON),
    .DMT_SW_ON(DMT_SW_ON), .WDT_CFG(WDT_CFG), .DMT_CFG(DMT_CFG),
    .SELF_TEST_RUN(SELF_TEST_RUN), .DEBUG_PORT_ENABLE(DEBUG_PORT_ENABLE),
    .DEBUG_PAIR_ONEHOT(DEBUG_PAIR_ONEHOT)
  );

  // --------------------------------------------------------------------
  // Clock and hang guard
  // --------------------------------------------------------------------
  initial begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end

  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic print_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Holds the request until the edge that samples waitrequest low
  task automatic bus(input logic [7:0] a, input logic wr_n_rd,
                     input logic [31:0] wd);
    @(posedge CLOCK);
    AVS_ADDRESS   <= a;
    AVS_WRITEDATA <= wd;
    AVS_WRITE     <= wr_n_rd;
    AVS_READ      <= ~wr_n_rd;
    do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
    rdat = AVS_READDATA;
    rrsp = AVS_RESPONSE;
    AVS_WRITE <= 1'b0;
    AVS_READ  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    bus(a, 1'b1, wd);
  endtask

  task automatic rdchk(input string name, input logic [7:0] a,
                       input logic [31:0] exp);
    bus(a, 1'b0, 32'h0000_0000);
    chk(name, rdat, exp);
  endtask

  // Reset, then count self-test pulses after release
  task automatic do_reset(input logic por);
    @(posedge CLOCK);
    POR_FLAG <= por;
    SYS_RST  <= 1'b1;
    repeat (6) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    pulses = 0;
    repeat (10) begin
      @(posedge CLOCK);
      if (SELF_TEST_RUN === 1'b1)
        pulses++;
    end
  endtask

  task automatic set_state(input logic slp, input logic osc,
                           input logic wsw, input logic dsw);
    @(posedge CLOCK);
    SLEEPING      <= slp;
    SYSCLK_INTERNAL_OSCILLATOR <= osc;
    WDT_SW_ON     <= wsw;
    DMT_SW_ON     <= dsw;
    repeat (6) @(posedge CLOCK);
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  initial begin
    n_fail = 0; tests_run = 0; cyc = 0;
    SYS_RST = 1'b1; POR_FLAG = 1'b1; AVS_ADDRESS = 8'h00;
    AVS_READ = 1'b0; AVS_WRITE = 1'b0; AVS_WRITEDATA = 32'h0000_0000;
    AVS_BYTEENABLE = 4'hF; SLEEPING = 1'b0; SYSCLK_INTERNAL_OSCILLATOR = 1'b0;
    WDT_SW_ON = 1'b0; DMT_SW_ON = 1'b0;
    do_reset(1'b1);
    wr(`CFGW_OFS_CTRL, 32'h0000_0001);
    for (int i = 0; i < 8; i++)
      rdchk("erased word", 8'(i * 4), 32'h00FF_FFFF);
    bus(8'h40, 1'b0, 32'h0000_0000);
    chk("unmapped rsp", 32'(rrsp), 32'h0000_0002);
    chk("unmapped data", rdat, 32'h0000_0000);
    wr(8'h40, 32'h0000_0000);
    chk("unmapped wr rsp", 32'(rrsp), 32'h0000_0002);
    rdchk("ctrl reads zero", `CFGW_OFS_CTRL, 32'h0000_0000);
    // First image: windowed, fast RC code, deadman locked on
    wr(`CFGW_OFS_WDT,  32'h0000_0E5F);
    wr(`CFGW_OFS_POR,  32'h0000_0000);
    wr(`CFGW_OFS_ICD,  32'h00FF_FFFE);
    wr(`CFGW_OFS_IVTL, 32'h0000_1234);
    wr(`CFGW_OFS_IVTH, 32'h0000_ABCD);
    wr(`CFGW_OFS_CNTL, 32'h0000_5678);
    wr(`CFGW_OFS_CNTH, 32'h0000_9ABC);
    wr(`CFGW_OFS_DMT,  32'h0000_0000);
    wr(`CFGW_OFS_WDT,  32'h00FF_FFFF);
    rdchk("wdt word", `CFGW_OFS_WDT, 32'h00FF_0E5F);
    rdchk("por word", `CFGW_OFS_POR, 32'h00FF_FFBF);
    rdchk("icd word", `CFGW_OFS_ICD, 32'h00FF_FFFE);
    rdchk("dmt word", `CFGW_OFS_DMT, 32'h00FF_FFFE);
    do_reset(1'b0);
    chk("bist warm", 32'(pulses), 32'h0000_0000);
    do_reset(1'b1);
    chk("bist por", 32'(pulses), 32'h0000_0001);
    rdchk("status", `CFGW_OFS_STAT, 32'h0000_0007);
    set_state(1'b0, 1'b0, 1'b0, 1'b0);
    chk("hw enable off", 32'(WDT_CFG.hw_enable), 32'h0000_0000);
    chk("run divide", WDT_CFG.divide, 32'h8000_0000);
    chk("window size", 32'(WDT_CFG.window_size_select), 32'h0000_0002);
    chk("window mode", 32'(WDT_CFG.window_mode), 32'h0000_0001);
    chk("clk fast", 32'(WDT_CFG.clk_onehot), 32'h0000_0002);
    chk("interval", DMT_CFG.deadman_window_interval, 32'hABCD_1234);
    chk("count", DMT_CFG.deadman_count_timeout, 32'h9ABC_5678);
    chk("dmt locked", 32'(DMT_CFG.deadman_enabled), 32'h0000_0001);
    chk("jtag", 32'(DEBUG_PORT_ENABLE), 32'h0000_0001);
    chk("pair two", 32'(DEBUG_PAIR_ONEHOT), 32'h0000_0002);
    set_state(1'b0, 1'b0, 1'b1, 1'b0);
    chk("hw enable sw", 32'(WDT_CFG.hw_enable), 32'h0000_0001);
    set_state(1'b0, 1'b1, 1'b1, 1'b0);
    chk("clk fast osc", 32'(WDT_CFG.clk_onehot), 32'h0000_0001);
    set_state(1'b1, 1'b0, 1'b1, 1'b0);
    chk("sleep divide", WDT_CFG.divide, 32'h0000_0008);
    chk("clk fast slp", 32'(WDT_CFG.clk_onehot), 32'h0000_0001);
    // Second image: peripheral clock, hardware on, deadman by software
    wr(`CFGW_OFS_CTRL, 32'h0000_0001);
    wr(`CFGW_OFS_WDT,  32'h0000_FC3F);
    set_state(1'b0, 1'b0, 1'b0, 1'b0);
    chk("held window", 32'(WDT_CFG.window_size_select), 32'h0000_0002);
    do_reset(1'b1);
    chk("bist off", 32'(pulses), 32'h0000_0000);
    set_state(1'b0, 1'b0, 1'b0, 1'b0);
    chk("hw enable on", 32'(WDT_CFG.hw_enable), 32'h0000_0001);
    chk("window 75", 32'(WDT_CFG.window_size_select), 32'h0000_0000);
    chk("clk periph", 32'(WDT_CFG.clk_onehot), 32'h0000_0004);
    chk("dmt off", 32'(DMT_CFG.deadman_enabled), 32'h0000_0000);
    chk("pair one", 32'(DEBUG_PAIR_ONEHOT), 32'h0000_0001);
    set_state(1'b1, 1'b0, 1'b0, 1'b1);
    chk("clk periph slp", 32'(WDT_CFG.clk_onehot), 32'h0000_0001);
    chk("sleep div max", WDT_CFG.divide, 32'h8000_0000);
    chk("dmt sw on", 32'(DMT_CFG.deadman_enabled), 32'h0000_0001);
    print_verdict();
  end
endmodule // cfgw_bank_tb
